/* File: src/jtag_test_access_port.sv */
// boundary-scan test access port driven by a sampled test clock
// What this block does
// - mode select and data in are taken at each test clock rising edge only
// - data out changes at the test clock falling edge while shifting
// - data out is released except in data or instruction shift states and until the next falling edge after them
// - test reset forces the controller to reset on the system clock, no test clock edge needed
// - one mode-select bit per rising edge walks the controller states
// - data in feeds the selected instruction, identification or bypass register
`timescale 1ns/1ps
module jtag_test_access_port #(
    parameter logic [31:0] ID_VALUE = tap_pkg::ID_DEFAULT
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic testClk,
    input  wire logic modeSel,
    input  wire logic testDataIn,
    input  wire logic testResetn,
    output logic      testDataOut,
    output logic      testDataOutEn
);

    // ************************************************************
    // pin sampling
    // ************************************************************
    logic [3:0] pinSync;
    logic       tckPrev_q;

    pin_sync #(.WIDTH(4)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .async  ({testResetn, testClk, modeSel, testDataIn}),
        .sync   (pinSync)
    );

    wire trstActive = !pinSync[3];
    wire tckS       = pinSync[2];
    wire tmsS       = pinSync[1];
    wire tdiS       = pinSync[0];
    wire tckRise    = tckS && !tckPrev_q;
    wire tckFall    = !tckS && tckPrev_q;

    always_ff @(posedge clk) begin
        if (!resetn) tckPrev_q <= 1'b0;
        else         tckPrev_q <= tckS;
    end

    // ************************************************************
    // controller
    // ************************************************************
    tap_pkg::tap_state_t state_q, state_d;

    always_comb begin
        unique case (state_q)
            tap_pkg::ST_RESET:    state_d = tmsS ? tap_pkg::ST_RESET   : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE:     state_d = tmsS ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR:   state_d = tmsS ? tap_pkg::ST_SEL_IR  : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR:   state_d = tmsS ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR: state_d = tmsS ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR: state_d = tmsS ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR: state_d = tmsS ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR: state_d = tmsS ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPD_DR:   state_d = tmsS ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR:   state_d = tmsS ? tap_pkg::ST_RESET   : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR:   state_d = tmsS ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR: state_d = tmsS ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR: state_d = tmsS ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR: state_d = tmsS ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR: state_d = tmsS ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPD_IR:   state_d = tmsS ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
            default:              state_d = tap_pkg::ST_RESET;
        endcase
    end

    // test reset wins on any cycle, without a test clock edge
    always_ff @(posedge clk) begin
        if (!resetn || trstActive) state_q <= tap_pkg::ST_RESET;
        else if (tckRise)          state_q <= state_d;
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [tap_pkg::IR_WIDTH-1:0] irShift_q, ir_q;
    logic [tap_pkg::ID_WIDTH-1:0] idShift_q;
    logic                         bypass_q;

    wire inReset  = state_q == tap_pkg::ST_RESET;
    wire capIr    = state_q == tap_pkg::ST_CAP_IR;
    wire shIr     = state_q == tap_pkg::ST_SHIFT_IR;
    wire updIr    = state_q == tap_pkg::ST_UPD_IR;
    wire capDr    = state_q == tap_pkg::ST_CAP_DR;
    wire shDr     = state_q == tap_pkg::ST_SHIFT_DR;
    wire selId    = ir_q == tap_pkg::INS_IDCODE;
    wire selByp   = !selId;
    wire shifting = shIr || shDr;

    always_ff @(posedge clk) begin
        if (!resetn || inReset) ir_q <= tap_pkg::INS_IDCODE;
        else if (tckRise && updIr) ir_q <= irShift_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) irShift_q <= '0;
        else if (tckRise && capIr) irShift_q <= tap_pkg::IR_CAPTURE;
        else if (tckRise && shIr) irShift_q <= {tdiS, irShift_q[tap_pkg::IR_WIDTH-1:1]};
    end

    always_ff @(posedge clk) begin
        if (!resetn) idShift_q <= '0;
        else if (tckRise && capDr && selId) idShift_q <= ID_VALUE;
        else if (tckRise && shDr && selId) idShift_q <= {tdiS, idShift_q[tap_pkg::ID_WIDTH-1:1]};
    end

    always_ff @(posedge clk) begin
        if (!resetn) bypass_q <= 1'b0;
        else if (tckRise && capDr && selByp) bypass_q <= 1'b0;
        else if (tckRise && shDr && selByp) bypass_q <= tdiS;
    end

    // ************************************************************
    // serial output on falling edge
    // ************************************************************
    wire drBit  = selId ? idShift_q[0] : bypass_q;
    wire outBit = shIr ? irShift_q[0] : drBit;

    always_ff @(posedge clk) begin
        if (!resetn || trstActive) begin
            testDataOut   <= 1'b0;
            testDataOutEn <= 1'b0;
        end else if (tckFall) begin
            testDataOut   <= shifting ? outBit : 1'b0;
            testDataOutEn <= shifting;
        end
    end

    // ************************************************************
    // checks: pins and controller
    // ************************************************************
    // test reset acts on the next clock, no test clock edge needed
    trst_async_a: assert property (@(posedge clk) disable iff (!resetn)
        trstActive |=> state_q == tap_pkg::ST_RESET)
        else $error("test reset not honoured");
    state_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !tckRise && !trstActive |=> $stable(state_q))
        else $error("state moved without rising edge");
    five_ones_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && tmsS && state_q == tap_pkg::ST_SEL_IR && !trstActive |=> inReset)
        else $error("select-ir with mode one not to reset");
    sel_dr_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && tmsS && !trstActive && state_q == tap_pkg::ST_IDLE |=> state_q == tap_pkg::ST_SEL_DR)
        else $error("idle with mode one not to select-dr");
    sel_ir_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && tmsS && !trstActive && state_q == tap_pkg::ST_SEL_DR |=> state_q == tap_pkg::ST_SEL_IR)
        else $error("select-dr with mode one not to select-ir");
    resume_ir_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && !tmsS && !trstActive && state_q == tap_pkg::ST_EXIT2_IR |=> shIr)
        else $error("exit2-ir with mode zero not back to shift");
    reset_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && tmsS && inReset |=> inReset)
        else $error("reset left with mode one");
    state_onehot_a: assert property (@(posedge clk) disable iff (!resetn)
        $onehot(state_q))
        else $error("controller state not one-hot");
    id_after_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        inReset |=> selId)
        else $error("identification not selected after reset");

    // ************************************************************
    // checks: shift registers
    // ************************************************************
    ir_update_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && updIr && !trstActive |=> ir_q == $past(irShift_q))
        else $error("instruction not updated");
    ir_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && capIr |=> irShift_q == tap_pkg::IR_CAPTURE)
        else $error("instruction capture value wrong");
    ir_shift_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && shIr |=> irShift_q[tap_pkg::IR_WIDTH-1] == $past(tdiS))
        else $error("instruction shift did not take data in");
    id_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && capDr && selId |=> idShift_q == ID_VALUE)
        else $error("identification capture value wrong");
    id_shift_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && shDr && selId |=> idShift_q[tap_pkg::ID_WIDTH-1] == $past(tdiS))
        else $error("identification shift did not take data in");
    byp_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && capDr && selByp |=> !bypass_q)
        else $error("bypass did not capture zero");
    byp_shift_a: assert property (@(posedge clk) disable iff (!resetn)
        tckRise && shDr && selByp && !trstActive |=> bypass_q == $past(tdiS))
        else $error("bypass did not take data in");
    // shift registers move only on a sampled rising edge
    data_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !tckRise |=> $stable(irShift_q) && $stable(idShift_q) && $stable(bypass_q))
        else $error("shift register moved without rising edge");

    // ************************************************************
    // checks: serial output
    // ************************************************************
    // enable may outlast the shift state by one exit state, until the next fall
    out_release_a: assert property (@(posedge clk) disable iff (!resetn)
        testDataOutEn |-> shifting || state_q == tap_pkg::ST_EXIT1_DR || state_q == tap_pkg::ST_EXIT1_IR)
        else $error("data out driven outside shift");
    out_off_a: assert property (@(posedge clk) disable iff (!resetn)
        tckFall && !trstActive && !shifting |=> !testDataOutEn)
        else $error("data out not released at fall");
    en_on_a: assert property (@(posedge clk) disable iff (!resetn)
        tckFall && !trstActive && shifting |=> testDataOutEn)
        else $error("data out not driven while shifting");
    out_fall_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(testDataOut) |-> $past(tckFall) || $past(trstActive))
        else $error("data out changed off falling edge");
    trst_out_a: assert property (@(posedge clk) disable iff (!resetn)
        trstActive |=> !testDataOutEn && !testDataOut)
        else $error("data out not released by test reset");

    // ************************************************************
    // cover
    // ************************************************************
    cov_shift_dr: cover property (@(posedge clk) shDr && tckRise && selId);
    cov_shift_ir: cover property (@(posedge clk) shIr && tckRise);
    cov_bypass:   cover property (@(posedge clk) shDr && selByp && testDataOutEn);
    cov_trst:     cover property (@(posedge clk) trstActive && !inReset);
    cov_pause_ir: cover property (@(posedge clk) state_q == tap_pkg::ST_PAUSE_IR && tckRise);

endmodule // jtag_test_access_port

/* File: src/tap_pkg.sv */
// constants shared by the test access port files
package tap_pkg;

    // ************************************************************
    // instruction register
    // ************************************************************
    localparam int          IR_WIDTH     = 4;
    localparam logic [3:0]  IR_CAPTURE   = 4'h1;
    localparam logic [3:0]  INS_EXTEST   = 4'h0;
    localparam logic [3:0]  INS_IDCODE   = 4'h2;
    localparam logic [3:0]  INS_BYPASS   = 4'hF;

    // ************************************************************
    // identification register
    // ************************************************************
    localparam int          ID_WIDTH     = 32;
    // value is arbitrary, bit 0 must be one
    localparam logic [31:0] ID_DEFAULT   = 32'h0000_1001;

    // ************************************************************
    // controller states, one-hot
    // ************************************************************
    typedef enum logic [15:0] {
        ST_RESET     = 16'h0001,
        ST_IDLE      = 16'h0002,
        ST_SEL_DR    = 16'h0004,
        ST_CAP_DR    = 16'h0008,
        ST_SHIFT_DR  = 16'h0010,
        ST_EXIT1_DR  = 16'h0020,
        ST_PAUSE_DR  = 16'h0040,
        ST_EXIT2_DR  = 16'h0080,
        ST_UPD_DR    = 16'h0100,
        ST_SEL_IR    = 16'h0200,
        ST_CAP_IR    = 16'h0400,
        ST_SHIFT_IR  = 16'h0800,
        ST_EXIT1_IR  = 16'h1000,
        ST_PAUSE_IR  = 16'h2000,
        ST_EXIT2_IR  = 16'h4000,
        ST_UPD_IR    = 16'h8000
    } tap_state_t;

endpackage

/* File: src/pin_sync.sv */
// two-stage synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_q <= '0;
            sync   <= '0;
        end else begin
            meta_q <= async;
            sync   <= meta_q;
        end
    end
endmodule // pin_sync

/* File: tb/jtag_controller_model.sv */
// behavioural boundary-scan test controller driving the test pins
`timescale 1ns/1ps
module jtag_controller_model (
    input  wire logic clk,
    input  wire logic tdoPin,
    output logic      testClk,
    output logic      modeSel,
    output logic      testDataIn,
    output logic      obsStrobe,
    output logic      obsTdo
);
    initial begin
        testClk = 1'b0;
        modeSel = 1'b1;
        testDataIn = 1'b0;
        obsStrobe = 1'b0;
        obsTdo = 1'b0;
    end
    // one test clock period, 8 system clocks; clock idles low between calls
    task automatic step(input logic tms, input logic tdi);
        modeSel = tms;
        testDataIn = tdi;
        repeat (4) @(negedge clk);
        testClk = 1'b1;
        @(negedge clk);
        obsTdo = tdoPin;
        obsStrobe = 1'b1;
        repeat (2) @(negedge clk);
        obsStrobe = 1'b0;
        modeSel = ~tms;
        testDataIn = ~tdi;
        @(negedge clk);
        testClk = 1'b0;
    endtask
endmodule // jtag_controller_model

/* File: tb/testbench.sv */
// self-checking bench for the test access port
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] ID_TB = 32'h6B2D_9E55; // arbitrary, bit 0 set
    logic        clk;
    logic        resetn;
    logic        testResetn;
    logic        testClk;
    logic        modeSel;
    logic        testDataIn;
    logic        testDataOut;
    logic        testDataOutEn;
    logic        obsStrobe;
    logic        obsTdo;
    logic        expQ[$];
    int          errors;
    int          samplesChecked;
    logic [31:0] seed;
    logic [3:0]  code;
    wire         tdoPin = testDataOutEn ? testDataOut : 1'bz;
    initial clk = 1'b0;
    always #50 clk = ~clk;
    jtag_test_access_port #(.ID_VALUE(ID_TB)) uut (.clk(clk), .resetn(resetn), .testClk(testClk),
        .modeSel(modeSel), .testDataIn(testDataIn), .testResetn(testResetn),
        .testDataOut(testDataOut), .testDataOutEn(testDataOutEn));
    jtag_controller_model partner (.clk(clk), .tdoPin(tdoPin), .testClk(testClk), .modeSel(modeSel),
        .testDataIn(testDataIn), .obsStrobe(obsStrobe), .obsTdo(obsTdo));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic step(input logic tms, input logic tdi, input logic expv);
        expQ.push_back(expv);
        partner.step(tms, tdi);
    endtask
    task automatic walk(input logic [7:0] tms, input int n);
        for (int i = 0; i < n; i++) begin
            step(tms[i], 1'b0, 1'bz);
        end
    endtask
    task automatic shift(input logic [31:0] din, input logic [31:0] expv, input int n, input logic leave);
        for (int i = 0; i < n; i++) begin
            step(leave && (i == n - 1), din[i], expv[i]);
        end
    endtask
    task automatic load_ir(input logic [3:0] c);
        walk(8'h03, 4);
        shift({28'h0, c}, 32'h1, 2, 1'b1);
        walk(8'h04, 4);
        shift({30'h0, c[3:2]}, 32'h0, 2, 1'b1);
        walk(8'h01, 2);
    endtask
    task automatic read_id();
        walk(8'h01, 3);
        shift(rnd(), ID_TB, 32, 1'b1);
        walk(8'h01, 2);
    endtask
    task automatic read_bypass();
        logic [31:0] d;
        d = rnd();
        walk(8'h01, 3);
        shift(d, {d[30:0], 1'b0}, 4, 1'b1);
        walk(8'h04, 4);
        shift(d >> 4, d >> 3, 4, 1'b1);
        walk(8'h01, 2);
    endtask
    always @(posedge obsStrobe) begin : monitor
        logic e;
        e = expQ.pop_front();
        samplesChecked++;
        if (obsTdo !== e) begin
            errors++;
            $display("wrong value at %0t: data out %b, expected %b", $time, obsTdo, e);
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        seed = 32'h0000_A0BC;
        errors = 0;
        samplesChecked = 0;
        resetn = 1'b0;
        testResetn = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        testResetn = 1'b1;
        repeat (4) @(negedge clk);
        walk(8'h00, 1);
        read_id();
        $display("test identification after reset done");
        for (int k = 0; k < 6; k++) begin
            code = (k < 3) ? ((k == 0) ? tap_pkg::INS_BYPASS : (k == 1) ? tap_pkg::INS_EXTEST
                : tap_pkg::INS_IDCODE) : 4'(rnd());
            load_ir(code);
            if (code === tap_pkg::INS_IDCODE) begin
                read_id();
            end else begin
                read_bypass();
            end
        end
        $display("test instruction codes done");
        load_ir(tap_pkg::INS_BYPASS);
        walk(8'h01, 3);
        shift(32'h0000_0005, 32'h0000_000A, 3, 1'b0);
        testResetn = 1'b0;
        repeat (5) @(negedge clk);
        testResetn = 1'b1;
        repeat (4) @(negedge clk);
        walk(8'h00, 1);
        read_id();
        $display("test reset in mid shift done");
        load_ir(tap_pkg::INS_BYPASS);
        walk(8'h1F, 5);
        walk(8'h00, 1);
        read_id();
        $display("test five ones to reset done");
        report_and_stop();
    end
endmodule // testbench
